// ### hw/amp_pkg.sv
package amp_pkg;
  // ----------------------------------------------------------------
  // Monitor channel message codes.
  // ----------------------------------------------------------------
  localparam logic [7:0] AMP_CMD_WR = 8'h85;
  localparam logic [7:0] AMP_CMD_RD = 8'h80;
  localparam logic [7:0] AMP_PIN_REG_ADDR = 8'h05;
  localparam logic [7:0] AMP_RESP_HDR = 8'h85;
  localparam logic [1:0] AMP_UP_OP_WR = 2'h1;
  localparam logic [1:0] AMP_UP_OP_RD = 2'h2;
  // ----------------------------------------------------------------
  // Command/indication codes and repetition.
  // ----------------------------------------------------------------
  localparam logic [3:0] AMP_CI_PIN_CHANGE = 4'h5;
  localparam logic [3:0] AMP_CI_IDLE = 4'hF;
  localparam logic [2:0] AMP_CI_REPEAT = 3'h4;
  // ----------------------------------------------------------------
  // Pin layout, reset values and strobe timing.
  // ----------------------------------------------------------------
  localparam logic [3:0] AMP_PIN_RESET = 4'h0;
  localparam logic [7:0] AMP_STD_OE = 8'hF0;
  localparam logic [7:0] AMP_UP_OE_CTRL = 8'h63;
  localparam logic [7:0] AMP_UP_OE_DATA = 8'h1C;
  localparam int AMP_UP_ADDR_LSB = 0;
  localparam int AMP_UP_DATA_LSB = 2;
  localparam int AMP_UP_WR_BIT = 5;
  localparam int AMP_UP_RD_BIT = 6;
  localparam logic [1:0] AMP_UP_STROBE_CYCLES = 2'h2;
  // ----------------------------------------------------------------
  // State types.
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {AMP_RX_CMD, AMP_RX_WDATA, AMP_RX_RADDR} amp_rx_state_t;
  typedef enum logic [1:0] {AMP_TX_IDLE, AMP_TX_HDR, AMP_TX_DATA} amp_tx_state_t;
  typedef enum logic [1:0] {AMP_UP_IDLE, AMP_UP_SETUP, AMP_UP_STROBE, AMP_UP_HOLD} amp_up_state_t;
endpackage

// ### hw/aux_maintenance_port.sv
`timescale 1ns/1ps
// Functional notes
// - Standard mode: four outputs, four inputs.
// - Standard mode: pins accessed only via monitor pin register.
// - Write data bits 7:4 drive pins.
// - Read answered with 85h then data.
// - Answer: written outputs high, inputs low.
// - Processor mode does strobed parallel pin accesses.
// - Pin change sends code 0101b four frames.
// - Interrupt pin sampled continuously.
// - Two bits select mode; both set invalid.
// - Reset: pins 3:0 inputs, 7:4 drive 0.
module aux_maintenance_port (
  // System clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Mode selection.
  input wire logic auxUpmodeCfg,
  input wire logic auxStdioSelect,
  // Interrupt input pin.
  input wire logic intPin,
  // Host bus link.
  input wire logic host_bit_clock,
  input wire logic frameSync,
  input wire logic monRxValid,
  input wire logic [7:0] monRxByte,
  output logic monTxValid,
  output logic [7:0] monTxByte,
  input wire logic monTxReady,
  output logic [3:0] ciCode,
  // Auxiliary pins.
  input wire logic [7:0] auxIn,
  output logic [7:0] auxOut,
  output logic [7:0] auxOe
);
  import amp_pkg::*;
  // ----------------------------------------------------------------
  // Interrupt pin sampling on the system clock.
  // ----------------------------------------------------------------
  logic intSync1_r, intSync2_r, intPrev_r, intTog_r;
  always_ff @(posedge sys_clk) begin
    intSync1_r <= intPin;
    intSync2_r <= intSync1_r;
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      intPrev_r <= intSync2_r;
      intTog_r <= 1'b0;
    end else begin
      intPrev_r <= intSync2_r;
      if (intSync2_r != intPrev_r) begin
        intTog_r <= ~intTog_r;
      end
    end
  end
  // ----------------------------------------------------------------
  // Crossings into the link domain.
  // ----------------------------------------------------------------
  logic linkRst1_r, linkRstN_r, upSync1_r, upSync2_r, stdSync1_r, stdSync2_r, togSync1_r, togSync2_r, togSync3_r;
  logic [7:0] inSync1_r, inSync2_r;
  always_ff @(posedge host_bit_clock) begin
    linkRst1_r <= reset_n;
    linkRstN_r <= linkRst1_r;
    upSync1_r <= auxUpmodeCfg;
    upSync2_r <= upSync1_r;
    stdSync1_r <= auxStdioSelect;
    stdSync2_r <= stdSync1_r;
    togSync1_r <= intTog_r;
    togSync2_r <= togSync1_r;
    togSync3_r <= togSync2_r;
    inSync1_r <= auxIn;
    inSync2_r <= inSync1_r;
  end
  logic upMode, badMode, ciEvent;
  assign upMode = upSync2_r & ~stdSync2_r;
  assign badMode = upSync2_r & stdSync2_r;
  assign ciEvent = togSync2_r ^ togSync3_r;
  // ----------------------------------------------------------------
  // Monitor message reception.
  // ----------------------------------------------------------------
  amp_rx_state_t rxState_r;
  logic wrData, rdAddr;
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      rxState_r <= AMP_RX_CMD;
    end else if (monRxValid) begin
      case (rxState_r)
        AMP_RX_CMD: begin
          if (monRxByte == AMP_CMD_WR) begin
            rxState_r <= AMP_RX_WDATA;
          end else if (monRxByte == AMP_CMD_RD) begin
            rxState_r <= AMP_RX_RADDR;
          end
        end
        default: rxState_r <= AMP_RX_CMD;
      endcase
    end
  end
  assign wrData = monRxValid && (rxState_r == AMP_RX_WDATA);
  assign rdAddr = monRxValid && (rxState_r == AMP_RX_RADDR);
  // ----------------------------------------------------------------
  // Pin register.
  // ----------------------------------------------------------------
  logic [3:0] pinReg_r;
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      pinReg_r <= AMP_PIN_RESET;
    end else if (wrData && !upMode && !badMode) begin
      pinReg_r <= monRxByte[7:4];
    end
  end
  // ----------------------------------------------------------------
  // Processor-port access sequencer.
  // ----------------------------------------------------------------
  amp_up_state_t upState_r;
  logic upWrite_r, upRdDone, upStart;
  logic [1:0] upAddr_r, upCnt_r;
  logic [2:0] upData_r;
  assign upStart = wrData && upMode && (upState_r == AMP_UP_IDLE)
    && ((monRxByte[7:6] == AMP_UP_OP_WR) || (monRxByte[7:6] == AMP_UP_OP_RD));
  assign upRdDone = (upState_r == AMP_UP_HOLD) && !upWrite_r;
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      upState_r <= AMP_UP_IDLE;
      upWrite_r <= 1'b0;
      upAddr_r <= 2'h0;
      upData_r <= 3'h0;
      upCnt_r <= 2'h0;
    end else begin
      case (upState_r)
        AMP_UP_IDLE: begin
          if (upStart) begin
            upState_r <= AMP_UP_SETUP;
            upWrite_r <= (monRxByte[7:6] == AMP_UP_OP_WR);
            upAddr_r <= monRxByte[5:4];
            upData_r <= monRxByte[2:0];
          end
        end
        AMP_UP_SETUP: begin
          upState_r <= AMP_UP_STROBE;
          upCnt_r <= AMP_UP_STROBE_CYCLES - 2'h1;
        end
        AMP_UP_STROBE: begin
          if (upCnt_r == 2'h0) begin
            upState_r <= AMP_UP_HOLD;
            if (!upWrite_r) begin
              upData_r <= inSync2_r[AMP_UP_DATA_LSB+:3];
            end
          end else begin
            upCnt_r <= upCnt_r - 2'h1;
          end
        end
        AMP_UP_HOLD: upState_r <= AMP_UP_IDLE;
        default: upState_r <= AMP_UP_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Pin drivers.
  // ----------------------------------------------------------------
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      auxOut <= {AMP_PIN_RESET, 4'h0};
      auxOe <= AMP_STD_OE;
    end else if (badMode) begin
      auxOut <= 8'h00;
      auxOe <= 8'h00;
    end else if (upMode) begin
      auxOut <= 8'h00;
      auxOut[AMP_UP_ADDR_LSB+:2] <= upAddr_r;
      auxOut[AMP_UP_DATA_LSB+:3] <= upData_r;
      auxOut[AMP_UP_WR_BIT] <= !((upState_r == AMP_UP_STROBE) && upWrite_r);
      auxOut[AMP_UP_RD_BIT] <= !((upState_r == AMP_UP_STROBE) && !upWrite_r);
      auxOe <= AMP_UP_OE_CTRL | ((upWrite_r && (upState_r != AMP_UP_IDLE)) ? AMP_UP_OE_DATA : 8'h00);
    end else begin
      auxOut <= {pinReg_r, 4'h0};
      auxOe <= AMP_STD_OE;
    end
  end
  // ----------------------------------------------------------------
  // Monitor message transmission.
  // ----------------------------------------------------------------
  amp_tx_state_t txState_r;
  logic [7:0] txData_r;
  logic pinRead;
  assign pinRead = rdAddr && (monRxByte == AMP_PIN_REG_ADDR) && !upMode && !badMode;
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      txState_r <= AMP_TX_IDLE;
      txData_r <= 8'h00;
      monTxByte <= 8'h00;
    end else begin
      case (txState_r)
        AMP_TX_IDLE: begin
          if (pinRead) begin
            txState_r <= AMP_TX_HDR;
            monTxByte <= AMP_RESP_HDR;
            txData_r <= {pinReg_r, inSync2_r[3:0]};
          end else if (upRdDone) begin
            txState_r <= AMP_TX_HDR;
            monTxByte <= AMP_CMD_WR;
            txData_r <= {AMP_UP_OP_RD, upAddr_r, 1'b1, upData_r};
          end
        end
        AMP_TX_HDR: begin
          if (monTxReady) begin
            txState_r <= AMP_TX_DATA;
            monTxByte <= txData_r;
          end
        end
        AMP_TX_DATA: begin
          if (monTxReady) begin
            txState_r <= AMP_TX_IDLE;
          end
        end
        default: txState_r <= AMP_TX_IDLE;
      endcase
    end
  end
  assign monTxValid = (txState_r != AMP_TX_IDLE);
  // ----------------------------------------------------------------
  // Pin-change indication.
  // ----------------------------------------------------------------
  logic [2:0] ciCnt_r;
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      ciCnt_r <= 3'h0;
    end else if (ciEvent) begin
      ciCnt_r <= AMP_CI_REPEAT;
    end else if (frameSync && (ciCnt_r != 3'h0)) begin
      ciCnt_r <= ciCnt_r - 3'h1;
    end
  end
  always_ff @(posedge host_bit_clock) begin
    if (!linkRstN_r) begin
      ciCode <= AMP_CI_IDLE;
    end else if (frameSync) begin
      ciCode <= (ciCnt_r != 3'h0) ? AMP_CI_PIN_CHANGE : AMP_CI_IDLE;
    end
  end
  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  property p_pin_write;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (wrData && !upMode && !badMode) |=> (pinReg_r == $past(monRxByte[7:4]));
  endproperty
  a_pin_write: assert property (p_pin_write) else $error("pin register not loaded");
  property p_std_pins;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (!upMode && !badMode) ##1 (!upMode && !badMode)
      |-> (auxOe == AMP_STD_OE) && (auxOut[7:4] == $past(pinReg_r)) && (auxOut[3:0] == 4'h0);
  endproperty
  a_std_pins: assert property (p_std_pins) else $error("standard pins wrong");
  property p_read_hdr;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (pinRead && !monTxValid) |=> monTxValid && (monTxByte == AMP_RESP_HDR);
  endproperty
  a_read_hdr: assert property (p_read_hdr) else $error("read header missing");
  property p_read_data;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (pinRead && !monTxValid) |=> (txData_r == {$past(pinReg_r), $past(inSync2_r[3:0])});
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");
  property p_ci_load;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      ciEvent |=> (ciCnt_r == AMP_CI_REPEAT);
  endproperty
  a_ci_load: assert property (p_ci_load) else $error("indication count not loaded");
  property p_ci_code;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (frameSync && (ciCnt_r != 3'h0)) |=> (ciCode == AMP_CI_PIN_CHANGE);
  endproperty
  a_ci_code: assert property (p_ci_code) else $error("indication code wrong");
  property p_int_sample;
    @(posedge sys_clk) disable iff (!reset_n)
      (intSync2_r != intPrev_r) |=> (intTog_r != $past(intTog_r));
  endproperty
  a_int_sample: assert property (p_int_sample) else $error("pin change missed");
  property p_strobe_width;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      (upMode && $fell(auxOut[AMP_UP_WR_BIT])) |-> ##1 !auxOut[AMP_UP_WR_BIT] ##1 auxOut[AMP_UP_WR_BIT];
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write strobe width wrong");
  property p_bad_mode;
    @(posedge host_bit_clock) disable iff (!linkRstN_r)
      badMode |=> (auxOe == 8'h00);
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("invalid mode drives pins");
endmodule

// ### test/amp_host_model.sv
`timescale 1ns/1ps
module amp_host_model (
  // Link framing.
  input wire logic host_bit_clock,
  output logic frameSync,
  // Monitor channel.
  output logic monRxValid,
  output logic [7:0] monRxByte,
  input wire logic monTxValid,
  input wire logic [7:0] monTxByte,
  output logic monTxReady
);
  int lag = 0;
  logic [3:0] fcnt = 4'h0;
  initial begin
    frameSync = 1'b0;
    monRxValid = 1'b0;
    monRxByte = 8'hFF;
    monTxReady = 1'b0;
  end
  // ----------------------------------------------------------------
  // Frame pulse every sixteen link cycles.
  // ----------------------------------------------------------------
  always @(posedge host_bit_clock) begin
    fcnt <= fcnt + 4'h1;
    frameSync <= (fcnt == 4'hF);
  end
  // ----------------------------------------------------------------
  // Two-byte message out; the line shows the inverse byte when idle.
  // ----------------------------------------------------------------
  task automatic send(input logic [7:0] b0, input logic [7:0] b1);
    @(posedge host_bit_clock);
    monRxValid <= 1'b1;
    monRxByte <= b0;
    @(posedge host_bit_clock);
    monRxByte <= b1;
    @(posedge host_bit_clock);
    monRxValid <= 1'b0;
    monRxByte <= ~b1;
  endtask
  // ----------------------------------------------------------------
  // Two-byte answer in, taken after lag cycles.
  // ----------------------------------------------------------------
  task automatic receive(output logic [7:0] hdr, output logic [7:0] dat);
    int n;
    hdr = 8'hXX;
    dat = 8'hXX;
    n = 0;
    while (monTxValid !== 1'b1 && n < 60) begin
      @(posedge host_bit_clock);
      n++;
    end
    if (n < 60) begin
      repeat (lag) @(posedge host_bit_clock);
      monTxReady <= 1'b1;
      @(posedge host_bit_clock);
      hdr = monTxByte;
      @(posedge host_bit_clock);
      dat = monTxByte;
      monTxReady <= 1'b0;
    end
  endtask
endmodule

// ### test/aux_maintenance_port_test.sv
`timescale 1ns/1ps
module aux_maintenance_port_test;
  import amp_pkg::*;
  logic sys_clk = 1'b0;
  logic host_bit_clock = 1'b0;
  logic reset_n, auxUpmodeCfg, auxStdioSelect, intPin;
  logic frameSync, monRxValid, monTxValid, monTxReady;
  logic [7:0] monRxByte, monTxByte, auxIn, auxOut, auxOe, h, d;
  logic [3:0] ciCode;
  int nFail = 0;
  int checksDone = 0;
  int n;
  int k;
  always #50 sys_clk = ~sys_clk;
  always #15 host_bit_clock = ~host_bit_clock;
  aux_maintenance_port dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .auxUpmodeCfg(auxUpmodeCfg),
    .auxStdioSelect(auxStdioSelect), .intPin(intPin), .host_bit_clock(host_bit_clock),
    .frameSync(frameSync), .monRxValid(monRxValid), .monRxByte(monRxByte), .monTxValid(monTxValid),
    .monTxByte(monTxByte), .monTxReady(monTxReady), .ciCode(ciCode), .auxIn(auxIn), .auxOut(auxOut),
    .auxOe(auxOe));
  amp_host_model host_u (.host_bit_clock(host_bit_clock), .frameSync(frameSync), .monRxValid(monRxValid),
    .monRxByte(monRxByte), .monTxValid(monTxValid), .monTxByte(monTxByte), .monTxReady(monTxReady));
  // ----------------------------------------------------------------
  // Checking and closing.
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checksDone++;
    if (got !== exp) begin
      nFail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checksDone, nFail);
    if (nFail == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic lk(input int c);
    repeat (c) @(posedge host_bit_clock);
    @(negedge sys_clk);
  endtask
  initial begin
    #3000000;
    nFail++;
    summarize();
  end
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    auxUpmodeCfg = 1'b0;
    auxStdioSelect = 1'b0;
    intPin = 1'b0;
    auxIn = 8'h00;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("reset out", 8'h00, auxOut);
    chk("reset oe", 8'hF0, auxOe);
    chk("reset ci", 8'h0F, {4'h0, ciCode});
    reset_n = 1'b1;
    lk(6);
    host_u.send(8'h81, 8'h30);
    lk(4);
    chk("ignored", 8'h00, {auxOut[7:4], 4'h0});
    host_u.send(AMP_CMD_WR, 8'hA5);
    lk(4);
    chk("pins", 8'hA0, {auxOut[7:4], 4'h0});
    chk("oe", 8'hF0, auxOe);
    auxStdioSelect = 1'b1;
    auxIn = 8'h5C;
    lk(4);
    for (int i = 0; i < 2; i++) begin
      host_u.lag = 3 * i;
      host_u.send(AMP_CMD_RD, AMP_PIN_REG_ADDR);
      host_u.receive(h, d);
      chk("rd hdr", 8'h85, h);
      chk("rd data", 8'hAC, d);
    end
    host_u.send(AMP_CMD_RD, 8'h06);
    lk(10);
    chk("no answer", 8'h00, {7'h00, monTxValid});
    for (int i = 0; i < 2; i++) begin
      intPin = ~intPin;
      n = 0;
      repeat (10) begin
        k = 0;
        do begin
          @(posedge host_bit_clock);
          k++;
        end while (frameSync !== 1'b1 && k < 40);
        if (k >= 40) begin
          chk("frame wait", 8'h01, 8'h00);
          summarize();
        end
        #1;
        n += (ciCode === AMP_CI_PIN_CHANGE);
      end
      chk("ci frames", 8'h04, 8'(n));
      chk("ci idle", 8'h0F, {4'h0, ciCode});
      @(negedge sys_clk);
    end
    auxUpmodeCfg = 1'b1;
    auxStdioSelect = 1'b0;
    auxIn = 8'h18;
    lk(4);
    chk("up oe", 8'h63, auxOe);
    chk("up idle", 8'h60, auxOut & 8'hE0);
    host_u.send(AMP_CMD_WR, {AMP_UP_OP_WR, 2'h2, 1'b0, 3'h5});
    n = 0;
    do begin
      @(posedge host_bit_clock);
      #1;
      n++;
    end while (auxOut[5] !== 1'b0 && n < 20);
    if (n >= 20) begin
      chk("wr strobe", 8'h00, 8'h01);
      summarize();
    end
    chk("wr bus", 8'h16, {3'h0, auxOut[4:0]});
    chk("wr oe", 8'h7F, auxOe);
    n = 0;
    while (auxOut[5] === 1'b0 && n < 10) begin
      @(posedge host_bit_clock);
      #1;
      n++;
    end
    chk("strobe len", 8'h02, 8'(n));
    host_u.send(AMP_CMD_WR, {AMP_UP_OP_RD, 2'h1, 1'b0, 3'h0});
    host_u.receive(h, d);
    chk("up hdr", 8'h85, h);
    chk("up data", 8'h9E, d);
    @(negedge sys_clk);
    auxStdioSelect = 1'b1;
    lk(4);
    chk("bad oe", 8'h00, auxOe);
    chk("bad out", 8'h00, auxOut);
    summarize();
  end
endmodule
